// *** src/sar_pkg.sv ***
// sar_pkg: constants, register map and types of the conversion sequencer
// assumes a 10 MHz apb clock and a converter core with a start/done handshake
// What this block does
// - every stored result is an unsigned 12-bit word: a converter core sample, or in limited scan the computed average
// - channel selector reaches 20 external plus 4 internal channels, each enabled alone
// - ten differential pairs, each switchable back to single-ended by configuration
// - conversion starts are paced to at most 200 k samples per second
// - single mode converts the selected channel once, then goes idle
// - burst mode converts one channel repeatedly, storing each result in turn
// - scan mode converts each enabled channel once except the odd channel of a differential pair, lowest number first, then stops
// - limited scan does a programmed number of conversions per channel, then advances
// - limited scan may drop a programmed count of first conversions per channel
// - limited scan may exclude largest and smallest result from the computed output
// - sweep mode repeats whole scans until software writes a stop
// - each channel has a result register with value, valid flag and overflow flag
package sar_pkg;
  localparam int NCH = 24;
  localparam int NEXT_CH = 20;
  localparam int NPAIR = 10;
  localparam int RES_W = 12;
  localparam int CLK_NS = 100;
  localparam int SAMPLE_NS = 5000;
  localparam int PACE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CHEN = 12'h004;
  localparam logic [11:0] OFF_DIFF = 12'h008;
  localparam logic [11:0] OFF_LCFG = 12'h00c;
  localparam logic [11:0] OFF_STAT = 12'h010;
  localparam logic [11:0] OFF_ISTAT = 12'h014;
  localparam logic [11:0] OFF_IMASK = 12'h018;
  localparam logic [11:0] OFF_DATA0 = 12'h040;
  localparam logic [11:0] OFF_DATAN = 12'h09c;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_START = 16;
  localparam int CTRL_STOP = 17;
  localparam int LCFG_DISC_LSB = 0;
  localparam int LCFG_K_LSB = 4;
  localparam int LCFG_MM = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CH_LSB = 8;
  localparam int DATA_VALID = 16;
  localparam int DATA_OVF = 17;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RES = 1;
  localparam int IRQ_OVF = 2;
  localparam logic [4:0] CH_RST = 5'h00;
  localparam logic [23:0] CHEN_RST = 24'h000000;
  localparam logic [9:0] DIFF_RST = 10'h000;
  localparam logic [3:0] DISC_RST = 4'h0;
  localparam logic [1:0] K_RST = 2'h0;
  localparam logic MM_RST = 1'b0;
  localparam logic [2:0] MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    MODE_SINGLE = 3'h0,
    MODE_BURST = 3'h1,
    MODE_SCAN = 3'h2,
    MODE_LIMIT = 3'h3,
    MODE_SWEEP = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PACE = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

  typedef struct packed {
    mode_t mode;
    logic [4:0] ch;
    logic [23:0] chen;
    logic [9:0] diff;
    logic [3:0] disc;
    logic [1:0] k;
    logic mm;
  } cfg_t;

  typedef struct packed {
    logic start;
    logic [4:0] ch;
    logic diff;
  } conv_req_t;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } conv_res_t;
endpackage

// *** src/sar_result_mem.sv ***
// sar_result_mem: per-channel result store with registered read data
// assumes write and read addresses stay below the depth
`timescale 1ns/1ps
`default_nettype none
module sar_result_mem #(
  parameter int W = 12,
  parameter int D = 24,
  parameter int AW = 5
) (
  // clock, reset and freeze
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk)
  begin
    if (ce && we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (ce && re)
      rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// *** src/sar_adc_conversion_sequencer.sv ***
// sar_adc_conversion_sequencer: apb-controlled sequencer for a 12-bit sar converter
// assumes a converter core that takes a start pulse and answers with one done pulse
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_sequencer #(
  parameter int unsigned PACE = sar_pkg::PACE_CYC
) (
  // clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // converter core
  output sar_pkg::conv_req_t conv_req,
  input wire sar_pkg::conv_res_t conv_res
);
  localparam int PW = $clog2(PACE + 1);
  localparam int NCH = sar_pkg::NCH;
  localparam int RW = sar_pkg::RES_W;

  logic setup;
  logic wr;
  logic rd;
  sar_pkg::cfg_t cfg_q;
  sar_pkg::cfg_t act_q;
  sar_pkg::cfg_t go_cfg;
  sar_pkg::state_t state_q;
  logic [2:0] mask_q;
  logic [2:0] istat_q;
  logic [2:0] ev;
  logic stop_q;
  logic [4:0] cur_q;
  logic [4:0] rep_q;
  logic dsel_q;
  logic [PW-1:0] pace_q;
  logic [15:0] sum_q;
  logic [RW-1:0] min_q;
  logic [RW-1:0] max_q;
  logic [NCH-1:0] valid_q;
  logic [NCH-1:0] ovf_q;
  logic [NCH-1:0] rclr;
  logic st_we;
  logic [RW-1:0] st_data;
  logic fin;
  logic adv;
  logic end_seq;
  logic go;
  logic scan_go;
  logic [4:0] go_ch;
  logic [5:0] first_go;
  logic [5:0] nxt;
  logic [5:0] restart;
  logic [4:0] last;
  logic [RW-1:0] d;
  logic [15:0] fsum;
  logic [15:0] kept;
  logic [15:0] avg16;
  logic [RW-1:0] fmin;
  logic [RW-1:0] fmax;
  logic [4:0] rd_idx;
  logic [RW-1:0] mem_rd;
  logic [31:0] rmux;
  logic [31:0] prdata_q;
  logic rdata_sel_q;
  logic [1:0] flag_q;
  logic fresh_q;
  logic ovf_ev;

  function automatic logic is_data(input logic [11:0] a);
    is_data = (a >= sar_pkg::OFF_DATA0) && (a <= sar_pkg::OFF_DATAN) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] data_idx(input logic [11:0] a);
    logic [11:0] o;
    o = a - sar_pkg::OFF_DATA0;
    data_idx = o[6:2];
  endfunction

  function automatic logic map_ok(input logic [11:0] a);
    map_ok = is_data(a) || a == sar_pkg::OFF_CTRL || a == sar_pkg::OFF_CHEN
      || a == sar_pkg::OFF_DIFF || a == sar_pkg::OFF_LCFG || a == sar_pkg::OFF_STAT
      || a == sar_pkg::OFF_ISTAT || a == sar_pkg::OFF_IMASK;
  endfunction

  // even channel of an enabled pair converts differentially
  function automatic logic pair_diff(input sar_pkg::cfg_t c, input logic [4:0] ch);
    pair_diff = (ch < 5'(sar_pkg::NEXT_CH)) && !ch[0] && c.diff[ch[4:1]];
  endfunction

  // lowest eligible channel at or above lo, found flag on top
  function automatic logic [5:0] first_from(input sar_pkg::cfg_t c, input logic [5:0] lo);
    logic [5:0] r;
    logic odd_in_pair;
    r = 6'h00;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      odd_in_pair = (i < sar_pkg::NEXT_CH) && (i % 2 == 1) && c.diff[i / 2];
      if ((6'(i) >= lo) && c.chen[i] && !odd_in_pair)
        r = {1'b1, 5'(i)};
    end
    first_from = r;
  endfunction

  // bus phases
  assign setup = psel & ~penable & ce;
  assign wr = psel & penable & ce & pwrite;
  assign rd = psel & penable & ce & ~pwrite;
  assign pready = ce;
  assign pslverr = psel & penable & ~map_ok(paddr);
  assign rd_idx = data_idx(paddr);

  // software configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q.mode <= sar_pkg::MODE_SINGLE;
      cfg_q.ch <= sar_pkg::CH_RST;
      cfg_q.chen <= sar_pkg::CHEN_RST;
      cfg_q.diff <= sar_pkg::DIFF_RST;
      cfg_q.disc <= sar_pkg::DISC_RST;
      cfg_q.k <= sar_pkg::K_RST;
      cfg_q.mm <= sar_pkg::MM_RST;
    end
    else if (wr)
    begin
      case (paddr)
        sar_pkg::OFF_CTRL:
        begin
          cfg_q.mode <= sar_pkg::mode_t'(pwdata[sar_pkg::CTRL_MODE_LSB +: 3]);
          cfg_q.ch <= pwdata[sar_pkg::CTRL_CH_LSB +: 5];
        end
        sar_pkg::OFF_CHEN: cfg_q.chen <= pwdata[NCH-1:0];
        sar_pkg::OFF_DIFF: cfg_q.diff <= pwdata[sar_pkg::NPAIR-1:0];
        sar_pkg::OFF_LCFG:
        begin
          cfg_q.disc <= pwdata[sar_pkg::LCFG_DISC_LSB +: 4];
          cfg_q.k <= pwdata[sar_pkg::LCFG_K_LSB +: 2];
          cfg_q.mm <= pwdata[sar_pkg::LCFG_MM];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= sar_pkg::MASK_RST;
    else if (wr && paddr == sar_pkg::OFF_IMASK)
      mask_q <= pwdata[2:0];
  end

  // start request; the write's own mode and channel apply
  always_comb
  begin
    go_cfg = cfg_q;
    go_cfg.mode = sar_pkg::mode_t'(pwdata[sar_pkg::CTRL_MODE_LSB +: 3]);
    go_cfg.ch = pwdata[sar_pkg::CTRL_CH_LSB +: 5];
  end

  assign first_go = first_from(go_cfg, 6'h00);
  assign scan_go = go_cfg.mode != sar_pkg::MODE_SINGLE && go_cfg.mode != sar_pkg::MODE_BURST;
  assign go_ch = scan_go ? first_go[4:0] : go_cfg.ch;
  assign go = wr && paddr == sar_pkg::OFF_CTRL && pwdata[sar_pkg::CTRL_START]
    && state_q == sar_pkg::ST_IDLE
    && pwdata[sar_pkg::CTRL_MODE_LSB +: 3] <= sar_pkg::MODE_SWEEP
    && (scan_go ? first_go[5] : go_cfg.ch < 5'(NCH));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_q <= 1'b0;
    else if (ce && state_q == sar_pkg::ST_IDLE)
      stop_q <= 1'b0;
    else if (wr && paddr == sar_pkg::OFF_CTRL && pwdata[sar_pkg::CTRL_STOP])
      stop_q <= 1'b1;
  end

  // limited-scan arithmetic
  assign d = conv_res.data;
  assign last = 5'({1'b0, act_q.disc} + (5'h01 << act_q.k) + (act_q.mm ? 5'h02 : 5'h00) - 5'h01);
  assign fsum = sum_q + {4'h0, d};
  assign fmin = (d < min_q) ? d : min_q;
  assign fmax = (d > max_q) ? d : max_q;
  assign kept = act_q.mm ? fsum - {4'h0, fmin} - {4'h0, fmax} : fsum;
  assign avg16 = kept >> act_q.k;
  assign nxt = first_from(act_q, {1'b0, cur_q} + 6'h01);
  assign restart = first_from(act_q, 6'h00);

  // per-conversion decision
  always_comb
  begin
    st_we = 1'b0;
    st_data = d;
    fin = 1'b0;
    adv = 1'b0;
    if (state_q == sar_pkg::ST_WAIT && conv_res.done)
    begin
      unique case (act_q.mode)
        sar_pkg::MODE_SINGLE:
        begin
          st_we = 1'b1;
          fin = 1'b1;
        end
        sar_pkg::MODE_BURST:
        begin
          st_we = 1'b1;
          fin = stop_q;
        end
        sar_pkg::MODE_SCAN, sar_pkg::MODE_SWEEP:
        begin
          st_we = 1'b1;
          adv = 1'b1;
        end
        sar_pkg::MODE_LIMIT:
        begin
          if (rep_q == last)
          begin
            st_we = 1'b1;
            st_data = avg16[RW-1:0];
            adv = 1'b1;
          end
        end
        default: fin = 1'b1;
      endcase
    end
  end

  assign end_seq = fin || (adv && !nxt[5]
    && !(act_q.mode == sar_pkg::MODE_SWEEP && !stop_q));

  // sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= sar_pkg::ST_IDLE;
      act_q.mode <= sar_pkg::MODE_SINGLE;
      act_q.ch <= sar_pkg::CH_RST;
      act_q.chen <= sar_pkg::CHEN_RST;
      act_q.diff <= sar_pkg::DIFF_RST;
      act_q.disc <= sar_pkg::DISC_RST;
      act_q.k <= sar_pkg::K_RST;
      act_q.mm <= sar_pkg::MM_RST;
      cur_q <= sar_pkg::CH_RST;
      dsel_q <= 1'b0;
      rep_q <= 5'h00;
      pace_q <= '0;
    end
    else if (ce)
    begin
      if (pace_q != '0)
        pace_q <= pace_q - PW'(1);
      unique case (state_q)
        sar_pkg::ST_IDLE:
        begin
          if (go)
          begin
            act_q <= go_cfg;
            cur_q <= go_ch;
            dsel_q <= pair_diff(go_cfg, go_ch);
            rep_q <= 5'h00;
            state_q <= sar_pkg::ST_PACE;
          end
        end
        sar_pkg::ST_PACE:
        begin
          if (pace_q == '0)
          begin
            pace_q <= PW'(PACE - 1);
            state_q <= sar_pkg::ST_WAIT;
          end
        end
        sar_pkg::ST_WAIT:
        begin
          if (conv_res.done)
          begin
            if (end_seq)
              state_q <= sar_pkg::ST_IDLE;
            else
              state_q <= sar_pkg::ST_PACE;
            if (adv)
            begin
              cur_q <= nxt[5] ? nxt[4:0] : restart[4:0];
              dsel_q <= pair_diff(act_q, nxt[5] ? nxt[4:0] : restart[4:0]);
              rep_q <= 5'h00;
            end
            else
              rep_q <= rep_q + 5'h01;
          end
        end
        default: state_q <= sar_pkg::ST_IDLE;
      endcase
    end
  end

  // accumulation over kept conversions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sum_q <= 16'h0000;
      min_q <= {RW{1'b1}};
      max_q <= '0;
    end
    else if (ce && (go || adv))
    begin
      sum_q <= 16'h0000;
      min_q <= {RW{1'b1}};
      max_q <= '0;
    end
    else if (ce && state_q == sar_pkg::ST_WAIT && conv_res.done
      && rep_q >= {1'b0, act_q.disc})
    begin
      sum_q <= fsum;
      min_q <= fmin;
      max_q <= fmax;
    end
  end

  assign conv_req.start = ce && state_q == sar_pkg::ST_PACE && pace_q == '0;
  assign conv_req.ch = cur_q;
  assign conv_req.diff = dsel_q;

  // result store
  sar_result_mem #(
    .W(RW),
    .D(NCH),
    .AW(5)
  ) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .we(st_we),
    .waddr(cur_q),
    .wdata(st_data),
    .re(setup),
    .raddr(rd_idx),
    .rdata(mem_rd)
  );

  // valid and overflow flags, store wins over read clear
  for (genvar g = 0; g < NCH; g++)
  begin : g_flag
    assign rclr[g] = rd && is_data(paddr) && rd_idx == 5'(g) && fresh_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        valid_q[g] <= 1'b0;
        ovf_q[g] <= 1'b0;
      end
      else if (ce)
      begin
        if (st_we && cur_q == 5'(g))
        begin
          valid_q[g] <= 1'b1;
          ovf_q[g] <= (ovf_q[g] | valid_q[g]) & ~rclr[g];
        end
        else if (rclr[g])
        begin
          valid_q[g] <= 1'b0;
          ovf_q[g] <= 1'b0;
        end
      end
    end
  end

  // interrupt status, read clears only what the read returned
  assign ovf_ev = st_we && valid_q[cur_q] && !rclr[cur_q];
  always_comb
  begin
    ev = 3'h0;
    ev[sar_pkg::IRQ_DONE] = ce && state_q == sar_pkg::ST_WAIT && conv_res.done && end_seq;
    ev[sar_pkg::IRQ_RES] = ce && st_we;
    ev[sar_pkg::IRQ_OVF] = ce && ovf_ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_q <= 3'h0;
    else if (rd && paddr == sar_pkg::OFF_ISTAT)
      istat_q <= (istat_q & ~prdata_q[2:0]) | ev;
    else
      istat_q <= istat_q | ev;
  end

  assign irq = |(istat_q & mask_q);

  // read mux, sampled in the setup phase
  always_comb
  begin
    rmux = 32'h00000000;
    case (paddr)
      sar_pkg::OFF_CTRL:
      begin
        rmux[sar_pkg::CTRL_MODE_LSB +: 3] = cfg_q.mode;
        rmux[sar_pkg::CTRL_CH_LSB +: 5] = cfg_q.ch;
      end
      sar_pkg::OFF_CHEN: rmux[NCH-1:0] = cfg_q.chen;
      sar_pkg::OFF_DIFF: rmux[sar_pkg::NPAIR-1:0] = cfg_q.diff;
      sar_pkg::OFF_LCFG:
      begin
        rmux[sar_pkg::LCFG_DISC_LSB +: 4] = cfg_q.disc;
        rmux[sar_pkg::LCFG_K_LSB +: 2] = cfg_q.k;
        rmux[sar_pkg::LCFG_MM] = cfg_q.mm;
      end
      sar_pkg::OFF_STAT:
      begin
        rmux[sar_pkg::STAT_BUSY] = state_q != sar_pkg::ST_IDLE;
        rmux[sar_pkg::STAT_CH_LSB +: 5] = cur_q;
      end
      sar_pkg::OFF_ISTAT: rmux[2:0] = istat_q;
      sar_pkg::OFF_IMASK: rmux[2:0] = mask_q;
      default: rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h00000000;
      rdata_sel_q <= 1'b0;
      flag_q <= 2'h0;
      fresh_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= rmux;
      rdata_sel_q <= is_data(paddr);
      flag_q <= {ovf_q[rd_idx], valid_q[rd_idx]};
      fresh_q <= !(st_we && cur_q == rd_idx);
    end
  end

  always_comb
  begin
    prdata = prdata_q;
    if (rdata_sel_q)
    begin
      prdata = 32'h00000000;
      prdata[RW-1:0] = mem_rd;
      prdata[sar_pkg::DATA_VALID] = flag_q[0];
      prdata[sar_pkg::DATA_OVF] = flag_q[1];
    end
  end
endmodule
`default_nettype wire

// *** sim/sar_seq_asserts.sv ***
// sar_seq_asserts: port-level checks of the sequencer's apb and converter link
// assumes one clock domain, ce low only while the sequencer is idle
`timescale 1ns/1ps
`default_nettype none
module sar_seq_asserts #(
  parameter int unsigned PACE = sar_pkg::PACE_CYC
) (
  // clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt
  input wire logic irq,
  // converter core
  input wire sar_pkg::conv_req_t conv_req,
  input wire sar_pkg::conv_res_t conv_res
);
  logic pend_q;
  logic [15:0] gap_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // conversion in flight and cycles since the last start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 1'b0;
    else if (ce && conv_req.start)
      pend_q <= 1'b1;
    else if (ce && conv_res.done)
      pend_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_q <= 16'hffff;
    else if (ce && conv_req.start)
      gap_q <= 16'h0001;
    else if (ce && gap_q != 16'hffff)
      gap_q <= gap_q + 16'h0001;
  end
  a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  a_start_gap: assert property (conv_req.start |-> gap_q >= PACE)
    else $error("starts closer than the pace interval");
  a_no_overlap: assert property (conv_req.start |-> !pend_q)
    else $error("start while a conversion is in flight");
  a_ch_hold: assert property (pend_q |-> $stable(conv_req.ch) && $stable(conv_req.diff))
    else $error("channel changed during a conversion");
  a_ch_range: assert property (conv_req.start |-> conv_req.ch < 5'h18)
    else $error("start on a channel beyond the selector");
  a_diff_even: assert property (conv_req.start && conv_req.diff |->
    !conv_req.ch[0] && conv_req.ch < 5'h14)
    else $error("differential start off an even external channel");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside an access phase");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  c_diff_start: cover property (conv_req.start && conv_req.diff);
  c_done: cover property (conv_res.done);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule
bind sar_adc_conversion_sequencer sar_seq_asserts #(.PACE(PACE)) u_chk (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .conv_req(conv_req), .conv_res(conv_res));
`default_nettype wire

// *** sim/adc_core_model.sv ***
// adc_core_model: behavioural converter core, one done pulse per start
// assumes the bench supplies sample value and latency each cycle
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and answer
  input wire sar_pkg::conv_req_t req,
  output sar_pkg::conv_res_t res,
  // sample and latency
  input wire logic [11:0] dval,
  input wire logic [2:0] lat
);
  logic [3:0] cnt_q;
  logic [11:0] hold_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      hold_q <= 12'h000;
      res <= '0;
    end
    else
    begin
      res.done <= 1'b0;
      res.data <= ~res.data;
      if (req.start)
      begin
        cnt_q <= {1'b0, lat} + 4'h1;
        hold_q <= dval;
      end
      else if (cnt_q != 4'h0)
      begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          res.done <= 1'b1;
          res.data <= hold_q;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/sar_adc_conversion_sequencer_tb.sv ***
// sar_adc_conversion_sequencer_tb: directed and random tests over apb
// assumes adc_core_model and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_sequencer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  sar_pkg::conv_req_t conv_req;
  sar_pkg::conv_res_t conv_res;
  logic [15:0] rnd = 16'h0035;
  logic [31:0] rdq;
  logic errq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nseq = 0;
  int nconv [24];
  logic [5:0] seq [8];
  logic [11:0] hist [24][8];
  logic [11:0] last [24];
  logic [4:0] mch = 5'h00;
  always #50 pclk = ~pclk;
  sar_adc_conversion_sequencer #(.PACE(2)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .conv_req(conv_req),
    .conv_res(conv_res));
  adc_core_model core (.clk(pclk), .rst_n(presetn), .req(conv_req), .res(conv_res),
    .dval(rnd[11:0]), .lat(rnd[14:12]));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [4:0] c,
    input logic s, input logic p);
    return 32'(m) | (32'(c) << 4) | (32'(s) << 16) | (32'(p) << 17);
  endfunction
  function automatic logic [31:0] dexp(input logic v, input logic o, input logic [11:0] d);
    return 32'(d) | (32'(v) << 16) | (32'(o) << 17);
  endfunction
  function automatic logic [11:0] daddr(input logic [4:0] c);
    return sar_pkg::OFF_DATA0 + 12'(4 * c);
  endfunction
  // kept samples 1..4 less min and max, halved
  function automatic logic [11:0] lim(input int c);
    logic [13:0] s;
    logic [11:0] mn;
    logic [11:0] mx;
    s = 14'h0;
    mn = 12'hfff;
    mx = 12'h000;
    for (int i = 1; i < 5; i++)
    begin
      s = s + 14'(hist[c][i]);
      if (hist[c][i] < mn)
        mn = hist[c][i];
      if (hist[c][i] > mx)
        mx = hist[c][i];
    end
    return 12'((s - 14'(mn) - 14'(mx)) >> 1);
  endfunction
  always @(posedge pclk)
    rnd <= lfsr(rnd);
  // record starts and results seen on the converter link
  always @(posedge pclk)
  begin
    if (conv_req.start)
    begin
      seq[nseq % 8] <= {conv_req.diff, conv_req.ch};
      nseq <= nseq + 1;
      mch <= conv_req.ch;
    end
    if (conv_res.done)
    begin
      hist[mch][nconv[mch] % 8] <= conv_res.data;
      last[mch] <= conv_res.data;
      nconv[mch] <= nconv[mch] + 1;
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle();
    rdq = 32'h1;
    while (rdq[0] !== 1'b0)
      apb(1'b0, sar_pkg::OFF_STAT, 32'h0);
  endtask
  task automatic wconv(input int c, input int k);
    while (nconv[c] < k)
      @(posedge pclk);
  endtask
  task automatic clr();
    for (int i = 0; i < 24; i++)
      nconv[i] = 0;
    nseq = 0;
  endtask
  initial
  begin
    logic [4:0] c;
    logic [11:0] offs [5];
    logic [5:0] ord [4];
    offs = '{sar_pkg::OFF_CHEN, sar_pkg::OFF_DIFF, sar_pkg::OFF_LCFG, sar_pkg::OFF_IMASK,
      sar_pkg::OFF_STAT};
    ord = '{6'h01, 6'h04, 6'h2a, 6'h16};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sar_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", rdq & 32'h1f7, 32'h0);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      chk("reg reset", rdq, 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'(errq), 32'h1);
    apb(1'b1, sar_pkg::OFF_CHEN, 32'h2);
    for (int m = 5; m < 8; m++)
    begin
      apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'(m), 5'h01, 1'b1, 1'b0));
      apb(1'b0, sar_pkg::OFF_STAT, 32'h0);
      chk("bad mode busy", 32'(rdq[0]), 32'h0);
    end
    $display("test reset_map finished");
    apb(1'b1, sar_pkg::OFF_IMASK, 32'h7);
    for (int i = 0; i < 3; i++)
    begin
      c = 5'(rnd % 16'h18);
      clr();
      apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h0, c, 1'b1, 1'b0));
      idle();
      chk("single count", nconv[c], 32'h1);
      @(negedge pclk);
      chk("irq set", 32'(irq), 32'h1);
      apb(1'b0, daddr(c), 32'h0);
      chk("single data", rdq, dexp(1'b1, 1'b0, last[c]));
      apb(1'b0, daddr(c), 32'h0);
      chk("flags cleared", rdq & 32'h30000, 32'h0);
      apb(1'b0, sar_pkg::OFF_ISTAT, 32'h0);
      chk("istat", rdq & 32'h7, 32'h3);
      @(negedge pclk);
      chk("irq clear", 32'(irq), 32'h0);
    end
    apb(1'b1, sar_pkg::OFF_IMASK, 32'h0);
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h0, 5'h00, 1'b1, 1'b0));
    idle();
    @(negedge pclk);
    chk("irq masked", 32'(irq), 32'h0);
    @(posedge pclk);
    ce <= 1'b0;
    fork
      apb(1'b1, sar_pkg::OFF_IMASK, 32'h2);
      begin
        repeat (5) @(negedge pclk);
        chk("irq frozen", 32'(irq), 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
      end
    join
    @(negedge pclk);
    chk("irq unmasked", 32'(irq), 32'h1);
    $display("test single_irq finished");
    clr();
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h1, 5'h03, 1'b1, 1'b0));
    wconv(3, 3);
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h0, 5'h09, 1'b1, 1'b0));
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h1, 5'h03, 1'b0, 1'b1));
    idle();
    chk("no change mid run", nconv[9], 32'h0);
    apb(1'b0, daddr(5'h03), 32'h0);
    chk("burst overflow", rdq, dexp(1'b1, 1'b1, last[3]));
    $display("test burst finished");
    clr();
    apb(1'b1, sar_pkg::OFF_CHEN, 32'h00400c12);
    apb(1'b1, sar_pkg::OFF_DIFF, 32'h20);
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h2, 5'h00, 1'b1, 1'b0));
    idle();
    chk("scan count", nseq, 32'h4);
    foreach (ord[i])
      chk("scan order", 32'(seq[i]), 32'(ord[i]));
    chk("odd skipped", nconv[11], 32'h0);
    apb(1'b0, daddr(5'h0a), 32'h0);
    chk("diff data", rdq, dexp(1'b1, 1'b0, last[10]));
    $display("test scan finished");
    clr();
    apb(1'b1, sar_pkg::OFF_DIFF, 32'h0);
    apb(1'b1, sar_pkg::OFF_CHEN, 32'h84);
    apb(1'b1, sar_pkg::OFF_LCFG, 32'h111);
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h3, 5'h00, 1'b1, 1'b0));
    idle();
    chk("limit count 2", nconv[2], 32'h5);
    chk("limit count 7", nconv[7], 32'h5);
    apb(1'b0, daddr(5'h02), 32'h0);
    chk("limit data 2", rdq, dexp(1'b1, 1'b0, lim(2)));
    apb(1'b0, daddr(5'h07), 32'h0);
    chk("limit data 7", rdq, dexp(1'b1, 1'b0, lim(7)));
    $display("test limited finished");
    clr();
    apb(1'b1, sar_pkg::OFF_CHEN, 32'h5);
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h4, 5'h00, 1'b1, 1'b0));
    wconv(0, 3);
    apb(1'b1, sar_pkg::OFF_CTRL, ctl(3'h4, 5'h00, 1'b0, 1'b1));
    idle();
    chk("sweep whole scans", nconv[2], nconv[0]);
    chk("sweep repeated", 32'(nconv[0] >= 3), 32'h1);
    $display("test sweep finished");
    test_done();
  end
endmodule
`default_nettype wire
